// >>> logic/dxc_pkg.sv
// Shared constants for the extended configuration register pair and its controller.
// Assumes a DRAM command bus sampled on rising link clock edges.
package dxc_pkg;
  localparam int unsigned ADDR_W          = 13;
  // Bank address codes that select each register
  localparam logic [1:0]  BA_EXT_ONE      = 2'h1;
  localparam logic [1:0]  BA_EXT_TWO      = 2'h2;
  // First register field positions
  localparam int unsigned E1_LOOP_OFF     = 0;
  localparam int unsigned E1_DRIVE_RED    = 1;
  localparam int unsigned E1_TERM_LO      = 2;
  localparam int unsigned E1_ADD_LO       = 3;
  localparam int unsigned E1_TERM_HI      = 6;
  localparam int unsigned E1_CAL_LO       = 7;
  localparam int unsigned E1_STROBE_OFF   = 10;
  localparam int unsigned E1_ZERO_BIT     = 11;
  localparam int unsigned E1_QUIET        = 12;
  // Second register field position and reserved mask, then first register field codes
  localparam int unsigned E2_HOT_RATE     = 7;
  localparam logic [12:0] E2_RSVD_MASK    = 13'h1f78;
  localparam logic [2:0]  ADD_RESERVED    = 3'h7;
  localparam logic [2:0]  CAL_EXIT        = 3'h0;
  localparam logic [2:0]  CAL_DEFAULT     = 3'h7;
  // Controller timing, in link clocks
  localparam int unsigned TMRD_CYC        = 2;
  localparam int unsigned LOOP_LOCK_CYC   = 200;
  // APB register offsets of the controller
  localparam logic [7:0]  OFF_CMD         = 8'h00;
  localparam logic [7:0]  OFF_STATUS      = 8'h04;
  localparam logic [7:0]  OFF_READBACK    = 8'h08;
  localparam logic [31:0] CMD_RESET_VAL   = 32'h0;
  typedef enum logic [1:0] {
    TERM_OFF = 2'h0,
    TERM_75  = 2'h1,
    TERM_150 = 2'h2,
    TERM_50  = 2'h3
  } dxc_term_t;
endpackage : dxc_pkg

// >>> logic/dxc_if.sv
// Command bus between the memory controller and the DRAM's configuration logic.
// Assumes the controller end drives ck from its own clock.
`timescale 1ns/1ps
`default_nettype none
interface dxc_if;
  logic        ck;
  logic        cke;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic [1:0]  ba;
  logic [12:0] addr;
  modport ctrl (output ck, output cke, output cs_n, output ras_n, output cas_n, output we_n,
                output ba, output addr);
  modport dram (input ck, input cke, input cs_n, input ras_n, input cas_n, input we_n,
                input ba, input addr);
endinterface : dxc_if
`default_nettype wire

// >>> logic/dxc_dram_cfg.sv
// DRAM end: decodes load-mode commands and holds both extended configuration registers.
// Assumes command pins are launched by the controller on the falling ck edge.
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - load-mode with bank code one fills register one
// - load-mode with bank code two fills register two
// - controller precharges all, holds enable high first; here it issues no precharge and refuses the load while banks_precharged is low
// - controller waits command cycle time after writes
// - contents undefined until programmed; valid flags shown
// - rewrites allowed only with banks precharged
// - controller keeps delay loop enabled; here bit zero is passed through as written, so the loop can be turned off
// - self-refresh gates loop off, exit restores it
// - 200 clocks after loop reset before reads
// - register one field map on address lines
// - controller drives bit eleven zero
// - calibration default exits with program 000
// - calibration adjust keeps additive delay
// - quiet bit disables data and strobe outputs
// - reserved bits of register two written zero
// - bit seven enables hot self-refresh rate
// - partial refresh may drop data in self-refresh
module dxc_dram_cfg (
  dxc_if.dram              bus,
  input  wire logic        rstn,
  output logic             cfg_valid_one,
  output logic             cfg_valid_two,
  output logic             loop_en,
  output logic             drive_reduced,
  output dxc_pkg::dxc_term_t term_sel,
  output logic [2:0]       additive_delay,
  output logic             add_delay_bad,
  output logic [2:0]       driver_calibration,
  output logic             strobe_comp_off,
  output logic             out_quiet,
  output logic             hot_refresh_rate,
  output logic             in_self_refresh,
  output logic [12:0]      ext_config_one,
  output logic [12:0]      ext_config_two
);
  logic        cke_prev_r;
  logic        ld_cmd;
  logic        sr_entry;
  logic        sr_exit;
  logic [12:0] one_r;
  logic [12:0] two_r;
  logic        v1_r;
  logic        v2_r;
  logic        sr_r;
  logic [3:0]  cmd_n;
  logic        hit_one;
  logic        hit_two;

  // Command decode at a ck rise; prev_cke is the enable level one rise earlier
  function automatic logic f_is_load(input logic prev_cke, input logic cur_cke, input logic [3:0] cmd);
    return prev_cke && cur_cke && cmd == 4'h0;
  endfunction : f_is_load

  function automatic logic f_is_sr_entry(input logic prev_cke, input logic cur_cke, input logic [3:0] cmd);
    return prev_cke && !cur_cke && cmd == 4'h1;
  endfunction : f_is_sr_entry

  function automatic logic f_selects(input logic [1:0] ba, input logic [1:0] code);
    return ba == code;
  endfunction : f_selects

  always_comb begin
    cmd_n    = {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};
    ld_cmd   = f_is_load(cke_prev_r, bus.cke, cmd_n);
    sr_entry = f_is_sr_entry(cke_prev_r, bus.cke, cmd_n);
    // Any enable rise ends self-refresh; after a power-down exit it clears a flag that is already low
    sr_exit  = !cke_prev_r && bus.cke;
    hit_one  = ld_cmd && f_selects(bus.ba, dxc_pkg::BA_EXT_ONE);
    hit_two  = ld_cmd && f_selects(bus.ba, dxc_pkg::BA_EXT_TWO);
  end

  always_ff @(posedge bus.ck or negedge rstn) begin
    if (!rstn) begin
      cke_prev_r <= 1'b0;
    end else begin
      cke_prev_r <= bus.cke;
    end
  end

  // Register contents are kept as written, reserved bits included, so a checker can
  // see what the controller drove; the valid flags mark programmed state.
  always_ff @(posedge bus.ck or negedge rstn) begin
    if (!rstn) begin
      one_r <= 13'h0;
      v1_r  <= 1'b0;
    end else if (hit_one) begin
      one_r <= bus.addr;
      v1_r  <= 1'b1;
    end
  end

  always_ff @(posedge bus.ck or negedge rstn) begin
    if (!rstn) begin
      two_r <= 13'h0;
      v2_r  <= 1'b0;
    end else if (hit_two) begin
      two_r <= bus.addr;
      v2_r  <= 1'b1;
    end
  end

  // Self-refresh holds the loop off without touching register one.
  always_ff @(posedge bus.ck or negedge rstn) begin
    if (!rstn) begin
      sr_r <= 1'b0;
    end else if (sr_entry) begin
      sr_r <= 1'b1;
    end else if (sr_exit) begin
      sr_r <= 1'b0;
    end
  end

  // Outputs registered one ck after the state they show, one process per field or pair of related outputs.
  always_ff @(posedge bus.ck or negedge rstn) begin
    if (!rstn) begin
      cfg_valid_one <= 1'b0;
      cfg_valid_two <= 1'b0;
    end else begin
      cfg_valid_one <= v1_r;
      cfg_valid_two <= v2_r;
    end
  end

  // Loop stays off until register one is programmed, whatever its reset contents.
  always_ff @(posedge bus.ck or negedge rstn) begin
    if (!rstn) begin
      loop_en <= 1'b0;
    end else begin
      loop_en <= v1_r && !one_r[dxc_pkg::E1_LOOP_OFF] && !sr_r;
    end
  end

  always_ff @(posedge bus.ck or negedge rstn) begin
    if (!rstn) begin
      drive_reduced <= 1'b0;
    end else begin
      drive_reduced <= one_r[dxc_pkg::E1_DRIVE_RED];
    end
  end

  always_ff @(posedge bus.ck or negedge rstn) begin
    if (!rstn) begin
      term_sel <= dxc_pkg::TERM_OFF;
    end else begin
      term_sel <= dxc_pkg::dxc_term_t'({one_r[dxc_pkg::E1_TERM_HI],
                                        one_r[dxc_pkg::E1_TERM_LO]});
    end
  end

  always_ff @(posedge bus.ck or negedge rstn) begin
    if (!rstn) begin
      additive_delay <= 3'h0;
      add_delay_bad  <= 1'b0;
    end else begin
      additive_delay <= one_r[dxc_pkg::E1_ADD_LO +: 3];
      add_delay_bad  <= one_r[dxc_pkg::E1_ADD_LO +: 3] == dxc_pkg::ADD_RESERVED;
    end
  end

  always_ff @(posedge bus.ck or negedge rstn) begin
    if (!rstn) begin
      driver_calibration <= 3'h0;
    end else begin
      driver_calibration <= one_r[dxc_pkg::E1_CAL_LO +: 3];
    end
  end

  always_ff @(posedge bus.ck or negedge rstn) begin
    if (!rstn) begin
      strobe_comp_off <= 1'b0;
    end else begin
      strobe_comp_off <= one_r[dxc_pkg::E1_STROBE_OFF];
    end
  end

  always_ff @(posedge bus.ck or negedge rstn) begin
    if (!rstn) begin
      out_quiet <= 1'b0;
    end else begin
      out_quiet <= v1_r && one_r[dxc_pkg::E1_QUIET];
    end
  end

  always_ff @(posedge bus.ck or negedge rstn) begin
    if (!rstn) begin
      hot_refresh_rate <= 1'b0;
    end else begin
      hot_refresh_rate <= v2_r && two_r[dxc_pkg::E2_HOT_RATE];
    end
  end

  always_ff @(posedge bus.ck or negedge rstn) begin
    if (!rstn) begin
      in_self_refresh <= 1'b0;
    end else begin
      in_self_refresh <= sr_r;
    end
  end

  always_ff @(posedge bus.ck or negedge rstn) begin
    if (!rstn) begin
      ext_config_one <= 13'h0;
      ext_config_two <= 13'h0;
    end else begin
      ext_config_one <= one_r;
      ext_config_two <= two_r;
    end
  end
endmodule : dxc_dram_cfg
`default_nettype wire

// >>> logic/dxc_ctrl.sv
// Controller end: APB-programmed sequencer issuing load-mode commands on the link.
// Assumes mclk is the only system clock; ck is mclk divided by two and driven out.
`timescale 1ns/1ps
`default_nettype none
module dxc_ctrl (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        banks_precharged,
  dxc_if.ctrl              bus
);
  // Command word: [12:0] contents, [13] select two, [14] go; go self-clears.
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_LOAD = 2'h1,
    ST_WAIT = 2'h2
  } dxc_st_t;

  dxc_st_t     st_r;
  logic        ck_r;
  logic [12:0] data_r;
  logic        sel_two_r;
  logic        go_r;
  logic        refused_r;
  logic [7:0]  wait_r;
  logic [12:0] last_one_r;
  logic [12:0] last_two_r;
  logic [12:0] sanit;
  logic        apb_wr;
  logic        apb_rd;
  logic        hit;

  always_comb begin
    apb_wr = psel && penable && pwrite;
    apb_rd = psel && penable && !pwrite;
    hit    = paddr == dxc_pkg::OFF_CMD || paddr == dxc_pkg::OFF_STATUS || paddr == dxc_pkg::OFF_READBACK;
    sanit  = pwdata[12:0];
    if (pwdata[13]) begin
      sanit = sanit & ~dxc_pkg::E2_RSVD_MASK;
    end else begin
      sanit[dxc_pkg::E1_ZERO_BIT] = 1'b0;
      // Adjust keeps the additive delay already programmed.
      if (pwdata[dxc_pkg::E1_CAL_LO +: 3] != dxc_pkg::CAL_EXIT &&
          pwdata[dxc_pkg::E1_CAL_LO +: 3] != dxc_pkg::CAL_DEFAULT) begin
        sanit[dxc_pkg::E1_ADD_LO +: 3] = last_one_r[dxc_pkg::E1_ADD_LO +: 3];
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= dxc_pkg::CMD_RESET_VAL;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !(paddr == dxc_pkg::OFF_CMD || paddr == dxc_pkg::OFF_STATUS ||
                                       paddr == dxc_pkg::OFF_READBACK);
      case (paddr)
        dxc_pkg::OFF_STATUS:   prdata <= {28'h0, refused_r, bus.cke, st_r != ST_IDLE, go_r};
        dxc_pkg::OFF_READBACK: prdata <= {3'h0, last_two_r, 3'h0, last_one_r};
        default:               prdata <= 32'h0;
      endcase
    end
  end

  // Refused when banks are not precharged; the request is dropped and flagged.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      go_r      <= 1'b0;
      data_r    <= 13'h0;
      sel_two_r <= 1'b0;
      refused_r <= 1'b0;
    end else if (apb_wr && pready && hit && paddr == dxc_pkg::OFF_CMD && pwdata[14] && !go_r) begin
      go_r      <= banks_precharged;
      refused_r <= !banks_precharged;
      data_r    <= sanit;
      sel_two_r <= pwdata[13];
    end else if (st_r == ST_LOAD && !ck_r) begin
      go_r <= 1'b0;
    end
  end

  // Link clock is mclk/2; commands change while ck is low so they are steady at its rise.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ck_r <= 1'b0;
    end else begin
      ck_r <= !ck_r;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_r       <= ST_IDLE;
      wait_r     <= 8'h0;
      last_one_r <= 13'h0;
      last_two_r <= 13'h0;
      bus.cke    <= 1'b0;
      bus.cs_n   <= 1'b1;
      bus.ras_n  <= 1'b1;
      bus.cas_n  <= 1'b1;
      bus.we_n   <= 1'b1;
      bus.ba     <= 2'h0;
      bus.addr   <= 13'h0;
    end else if (ck_r) begin
      bus.cke   <= 1'b1;
      bus.cs_n  <= 1'b1;
      bus.ras_n <= 1'b1;
      bus.cas_n <= 1'b1;
      bus.we_n  <= 1'b1;
      case (st_r)
        ST_IDLE: begin
          if (go_r && bus.cke) begin
            st_r      <= ST_LOAD;
            bus.cs_n  <= 1'b0;
            bus.ras_n <= 1'b0;
            bus.cas_n <= 1'b0;
            bus.we_n  <= 1'b0;
            bus.ba    <= sel_two_r ? dxc_pkg::BA_EXT_TWO : dxc_pkg::BA_EXT_ONE;
            bus.addr  <= data_r;
            if (sel_two_r) begin
              last_two_r <= data_r;
            end else begin
              last_one_r <= data_r;
            end
            // Loop enabled after being off needs the lock wait before reads.
            wait_r <= (!sel_two_r && !data_r[dxc_pkg::E1_LOOP_OFF] && last_one_r[dxc_pkg::E1_LOOP_OFF])
                      ? 8'(dxc_pkg::LOOP_LOCK_CYC) : 8'(dxc_pkg::TMRD_CYC);
          end
        end
        ST_LOAD: begin
          st_r <= ST_WAIT;
        end
        ST_WAIT: begin
          if (wait_r <= 8'h1) begin
            st_r <= ST_IDLE;
          end
          wait_r <= wait_r - 8'h1;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  assign bus.ck = ck_r;
endmodule : dxc_ctrl
`default_nettype wire

// >>> verification/dxc_chk.sv
// Checker on the command link between the controller and DRAM ends.
// Assumes ck is the link clock driven by the controller and rstn the shared async reset.
`timescale 1ns/1ps
`default_nettype none
module dxc_chk (
  input wire logic        ck,
  input wire logic        rstn,
  input wire logic        cke,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [1:0]  ba,
  input wire logic [12:0] addr
);
  logic       load;
  logic       off_r;
  logic       need_r;
  logic [7:0] gap_r;
  assign load = cke & !cs_n & !ras_n & !cas_n & !we_n;
  // Saturates so the first load after reset is never judged too early
  always_ff @(posedge ck or negedge rstn) begin
    if (!rstn) gap_r <= 8'hff;
    else if (load) gap_r <= 8'h0;
    else if (gap_r != 8'hff) gap_r <= gap_r + 8'h1;
  end
  always_ff @(posedge ck or negedge rstn) begin
    if (!rstn) off_r <= 1'b0;
    else if (load && ba == 2'h1) off_r <= addr[0];
  end
  // Set by a load that turns the delay loop back on
  always_ff @(posedge ck or negedge rstn) begin
    if (!rstn) need_r <= 1'b0;
    else if (load) need_r <= (ba == 2'h1) && off_r && !addr[0];
  end
  default clocking @(posedge ck); endclocking
  default disable iff (!rstn);
  property p_bank; load |-> (ba == 2'h1 || ba == 2'h2); endproperty
  property p_a11; load && ba == 2'h1 |-> !addr[11]; endproperty
  property p_rsvd; load && ba == 2'h2 |-> (addr & 13'h1f78) == 13'h0; endproperty
  property p_tmrd; load |=> !load [*2]; endproperty
  property p_cke; load |-> $past(cke); endproperty
  property p_hold; load |=> cke [*2]; endproperty
  property p_noread; !(cke && !cs_n && ras_n && !cas_n && we_n); endproperty
  property p_lock; load && need_r |-> gap_r >= 8'd199; endproperty
  a_bank: assert property (p_bank) else $error("load with bad bank code");
  a_a11: assert property (p_a11) else $error("bit eleven high");
  a_rsvd: assert property (p_rsvd) else $error("reserved bits high");
  a_tmrd: assert property (p_tmrd) else $error("load spacing too short");
  a_cke: assert property (p_cke) else $error("load without enable held");
  a_hold: assert property (p_hold) else $error("enable dropped after load");
  a_noread: assert property (p_noread) else $error("read issued");
  a_lock: assert property (p_lock) else $error("relock wait too short");
  c_one: cover property (load && ba == 2'h1);
  c_two: cover property (load && ba == 2'h2);
  c_relock: cover property (load && need_r);
endmodule : dxc_chk
`default_nettype wire

// >>> verification/test_dram_ext_mode_config.sv
// Bench joining controller and DRAM ends over the link, driven through APB.
// Assumes the controller makes ck from mclk and answers APB without wait states.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module test_dram_ext_mode_config;
  typedef struct packed {logic [14:0] cmd; logic [12:0] e1; logic [12:0] e2;} dxc_row_t;
  logic               mclk, rstn, psel, penable, pwrite, bp, pready, err;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic               v1, v2, loop_en, drv, bad, sboff, quiet, hot, sref;
  logic [2:0]         add, cal;
  dxc_pkg::dxc_term_t term;
  logic [12:0]        cfg1, cfg2;
  int                 checks, miscompares, cyc;
  dxc_row_t           rows [7];
  dxc_if bus ();
  dxc_ctrl u_dxc_ctrl (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(err),
    .banks_precharged(bp), .bus(bus));
  dxc_dram_cfg u_dxc_dram_cfg (.bus(bus), .rstn(rstn), .cfg_valid_one(v1), .cfg_valid_two(v2),
    .loop_en(loop_en), .drive_reduced(drv), .term_sel(term), .additive_delay(add), .add_delay_bad(bad),
    .driver_calibration(cal), .strobe_comp_off(sboff), .out_quiet(quiet), .hot_refresh_rate(hot),
    .in_self_refresh(sref), .ext_config_one(cfg1), .ext_config_two(cfg2));
  dxc_chk u_dxc_chk (.ck(bus.ck), .rstn(rstn), .cke(bus.cke), .cs_n(bus.cs_n), .ras_n(bus.ras_n),
    .cas_n(bus.cas_n), .we_n(bus.we_n), .ba(bus.ba), .addr(bus.addr));
  initial mclk = 1'b0;
  always #25 mclk = ~mclk;
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // Polls status until idle, then lets the DRAM end take up the value
  task automatic send(input logic [14:0] c);
    int n;
    n = 0;
    apb(1'b1, dxc_pkg::OFF_CMD, {17'h0, c});
    do begin apb(1'b0, dxc_pkg::OFF_STATUS, 32'h0); n++; end while (rd[1:0] !== 2'h0 && n < 600);
    repeat (3) @(posedge bus.ck);
  endtask : send
  initial begin
    rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
    bp = 1'b1; checks = 0; miscompares = 0; cyc = 0;
    rows = '{'{15'h4001, 13'h0001, 13'h0}, '{15'h4000, 13'h0, 13'h0}, '{15'h5fff, 13'h17ff, 13'h0},
             '{15'h7fff, 13'h17ff, 13'h0087}, '{15'h4444, 13'h0444, 13'h0087},
             '{15'h4098, 13'h0080, 13'h0087}, '{15'h6000, 13'h0080, 13'h0}};
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      send(rows[i].cmd);
      `CHK(cfg1, rows[i].e1)
      `CHK(cfg2, rows[i].e2)
      `CHK(rd[2:0], 3'h4)
      $display("row %0d done", i);
    end
    send(15'h5446);
    `CHK({v1, loop_en, drv, sboff, quiet}, 5'h1f)
    `CHK(term, dxc_pkg::TERM_50)
    `CHK(sref, 1'b0)
    send(15'h6080);
    `CHK({v2, hot}, 2'h3)
    send(15'h4038);
    `CHK(bad, 1'b1)
    `CHK({add, cal}, 6'h38)
    $display("fields done");
    bp <= 1'b0;
    send(15'h4001);
    `CHK(rd[3], 1'b1)
    `CHK(cfg1, 13'h0038)
    bp <= 1'b1;
    $display("refusal done");
    apb(1'b0, 8'h40, 32'h0);
    `CHK(err, 1'b1)
    $display("unmapped done");
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    `CHK({v1, v2, cfg1, cfg2}, 28'h0)
    rstn <= 1'b1;
    send(15'h4000);
    `CHK({v1, v2}, 2'h2)
    $display("reset done");
    stop_test();
  end
endmodule : test_dram_ext_mode_config
`default_nettype wire
